/* File: hw/ces_map.svh */
`ifndef CES_MAP_SVH
`define CES_MAP_SVH
// register offsets on the wishbone slave
`define CES_ADR_CSW   8'h00
`define CES_ADR_SSW   8'h04
`define CES_ADR_LINK  8'h08
`define CES_ADR_INFO  8'h0C
// exception vectors
`define CES_VEC_RESET 32'h00000000
`define CES_VEC_UNDEF 32'h00000004
`define CES_VEC_TRAP  32'h00000008
`define CES_VEC_PABT  32'h0000000C
`define CES_VEC_DABT  32'h00000010
`define CES_VEC_RSVD  32'h00000014
`define CES_VEC_IRQ   32'h00000018
`define CES_VEC_FIQ   32'h0000001C
// mode field encodings
`define CES_MODE_USR  5'h10
`define CES_MODE_FIQ  5'h11
`define CES_MODE_IRQ  5'h12
`define CES_MODE_SVC  5'h13
`define CES_MODE_ABT  5'h17
`define CES_MODE_UND  5'h1B
`define CES_MODE_SYS  5'h1F
// status word layout and reset value
`define CES_BIT_I     7
`define CES_BIT_F     6
`define CES_BIT_T     5
`define CES_CSW_RST   8'hD3
// link offsets and fast bank size
`define CES_LINK_NEAR 32'h00000004
`define CES_LINK_FAR  32'h00000008
`define CES_FAST_BANKED 8
`endif

/* File: hw/ces_pkg.sv */
package ces_pkg;
  // exception kinds
  typedef enum logic [2:0] {
    EXC_RESET = 3'h0,
    EXC_UNDEF = 3'h1,
    EXC_TRAP  = 3'h2,
    EXC_PABT  = 3'h3,
    EXC_DABT  = 3'h4,
    EXC_IRQ   = 3'h6,
    EXC_FIQ   = 3'h7
  } ces_exc_e;
  // instruction class in execute
  typedef enum logic [2:0] {
    OP_OTHER = 3'h0,
    OP_LOAD  = 3'h1,
    OP_STORE = 3'h2,
    OP_SWAP  = 3'h3,
    OP_LDM   = 3'h4,
    OP_BLKST = 3'h5
  } ces_op_e;
  // sequencer state
  typedef enum logic {
    ST_RUN   = 1'b0,
    ST_CHAIN = 1'b1
  } ces_state_e;
  // status word control bits
  typedef struct packed {
    logic       i;
    logic       f;
    logic       t;
    logic [4:0] mode;
  } ces_status_s;
  // memory cycle report
  typedef struct packed {
    logic done;
    logic fetch;
    logic write;
    logic abort;
  } ces_mem_s;
  // pipeline report
  typedef struct packed {
    logic        advance;
    logic        flush;
    logic        exec_valid;
    logic        cond_pass;
    logic        instr_end;
    logic        undef;
    logic        cp_accept;
    logic        swtrap;
    ces_op_e     op;
    logic        base_wb;
    logic        base_loaded;
    logic [31:0] pc;
  } ces_pipe_s;
  // entry command to the core
  typedef struct packed {
    logic        take;
    ces_exc_e    kind;
    logic [31:0] vector;
    logic [31:0] link;
    logic [4:0]  mode;
  } ces_entry_s;
  // write suppression strobes
  typedef struct packed {
    logic rf_block;
    logic mem_wr_block;
    logic base_revert;
    logic base_wb_ok;
    logic pc_keep;
  } ces_guard_s;
endpackage

/* File: hw/ces_sequencer.sv */
`timescale 1ns/10ps
`include "ces_map.svh"
// Behaviour
// - fast request passes two-flop synchronizer
// - fast request tested each boundary unless masked
// - normal request synchronized, below fast, masked
// - normal request ignored while its mask set
// - abort sampled at memory cycle end
// - fetch abort tags instruction until execute
// - unexecuted tagged instruction takes no abort
// - aborted single load blocks register write
// - swap read abort blocks write and register
// - swap write abort blocks register update
// - aborted block transfer completes with writeback
// - block load abort blocks writes, reverts base if loaded
// - aborted block load keeps program counter
// - fixed vectors, reserved slot never used
// - entry sets normal mask, fast mask only on reset or fast entry, and forces mode
// - unhandled instruction takes undefined trap
// - software trap enters supervisor mode
// - simultaneous exceptions resolved by fixed priority
// - data abort then fast entry immediately
// - fast mode banks eight registers in wide state only
// - entry saves link, status, forces vector
// - five-bit mode encodings
// - entry always in wide state
// - link is address plus four or eight
module ces_sequencer #(
  parameter int BANKED = `CES_FAST_BANKED // fast bank size
) (
  input  wire logic              clk_i,     // 40 MHz clock
  input  wire logic              rst_i,     // sync reset, high
  input  wire logic              ce_i,      // clock enable
  input  wire logic              wb_cyc_i,  // bus cycle
  input  wire logic              wb_stb_i,  // bus strobe
  input  wire logic              wb_we_i,   // bus write
  input  wire logic [7:0]        wb_adr_i,  // byte address
  input  wire logic [31:0]       wb_dat_i,  // write data
  input  wire logic [3:0]        wb_sel_i,  // byte lanes
  output logic      [31:0]       wb_dat_o,  // read data
  output logic                   wb_ack_o,  // bus ack
  input  wire logic              fast_request_n_i,   // pin, low
  input  wire logic              normal_request_n_i, // pin, low
  input  wire logic              reset_req_i, // reset request
  input  wire ces_pkg::ces_mem_s  mem_i,    // memory report
  input  wire ces_pkg::ces_pipe_s pipe_i,   // pipeline report
  output ces_pkg::ces_entry_s     entry_o,  // entry command
  output ces_pkg::ces_status_s    status_o, // current status
  output ces_pkg::ces_guard_s     guard_o,  // suppressions
  output logic      [BANKED-1:0] bank_map_o // fast bank select
);
  import ces_pkg::*;

  // vector per exception kind
  function automatic logic [31:0] vec_of(input ces_exc_e k);
    case (k)
      EXC_RESET: vec_of = `CES_VEC_RESET;
      EXC_UNDEF: vec_of = `CES_VEC_UNDEF;
      EXC_TRAP:  vec_of = `CES_VEC_TRAP;
      EXC_PABT:  vec_of = `CES_VEC_PABT;
      EXC_DABT:  vec_of = `CES_VEC_DABT;
      EXC_IRQ:   vec_of = `CES_VEC_IRQ;
      default:   vec_of = `CES_VEC_FIQ;
    endcase
  endfunction

  // entry mode per exception kind
  function automatic logic [4:0] mode_of(input ces_exc_e k);
    case (k)
      EXC_UNDEF:          mode_of = `CES_MODE_UND;
      EXC_PABT, EXC_DABT: mode_of = `CES_MODE_ABT;
      EXC_IRQ:            mode_of = `CES_MODE_IRQ;
      EXC_FIQ:            mode_of = `CES_MODE_FIQ;
      default:            mode_of = `CES_MODE_SVC;
    endcase
  endfunction

  // saved status slot per mode
  function automatic logic [2:0] slot_of(input logic [4:0] m);
    case (m)
      `CES_MODE_FIQ: slot_of = 3'h0;
      `CES_MODE_IRQ: slot_of = 3'h1;
      `CES_MODE_SVC: slot_of = 3'h2;
      `CES_MODE_ABT: slot_of = 3'h3;
      `CES_MODE_UND: slot_of = 3'h4;
      default:       slot_of = 3'h5;
    endcase
  endfunction

  logic        fq_s1_r, fq_s2_r;   // fast synchronizer
  logic        nq_s1_r, nq_s2_r;   // normal synchronizer
  ces_status_s csw_r;              // current status word
  logic [7:0]  ssw_r [6];          // saved status words
  logic [31:0] link_r;             // last saved link
  ces_exc_e    last_r;             // last exception kind
  ces_state_e  st_r;               // sequencer state
  ces_state_e  st_nxt;             // next state
  logic        tag_dec_r;          // abort tag in decode
  logic        tag_exe_r;          // abort tag in execute
  logic        da_pend_r;          // data abort pending
  logic        abt_seen_r;         // abort within instruction
  logic        ack_r;              // bus ack
  logic [31:0] rd_r;               // bus read data
  ces_entry_s  entry_r;            // registered entry

  // request qualification
  wire fiq_act  = ~fq_s2_r & ~csw_r.f;
  wire irq_act  = ~nq_s2_r & ~csw_r.i;
  wire bound    = ce_i & pipe_i.instr_end;
  wire executed = pipe_i.exec_valid & pipe_i.cond_pass;
  wire pabt_hit = tag_exe_r & executed;
  wire undef_hit = executed & pipe_i.undef
                 & ~pipe_i.cp_accept;
  wire trap_hit = executed & pipe_i.swtrap
                 & ~undef_hit;

  // memory abort sampling
  wire mem_end   = ce_i & mem_i.done & mem_i.abort;
  wire fetch_abt = mem_end & mem_i.fetch;
  wire dabt_now  = mem_end & ~mem_i.fetch;
  wire da_any    = dabt_now | da_pend_r;
  wire abt_any   = dabt_now | abt_seen_r;

  // fixed priority choice
  wire      chain_go = (st_r == ST_CHAIN) & ce_i & fiq_act;
  wire      norm_go  = bound & (da_any | fiq_act | irq_act
                     | pabt_hit | undef_hit | trap_hit);
  wire      take_w   = (ce_i & reset_req_i) | chain_go | norm_go;
  ces_exc_e kind_w;
  assign kind_w = reset_req_i ? EXC_RESET :
                  chain_go    ? EXC_FIQ   :
                  da_any      ? EXC_DABT  :
                  fiq_act     ? EXC_FIQ   :
                  irq_act     ? EXC_IRQ   :
                  pabt_hit    ? EXC_PABT  :
                  undef_hit   ? EXC_UNDEF : EXC_TRAP;
  wire [4:0]  new_mode = mode_of(kind_w);
  wire [31:0] link_w   = pipe_i.pc + ((kind_w == EXC_DABT)
                       ? `CES_LINK_FAR : `CES_LINK_NEAR);

  // state machine for abort to fast chaining
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      ST_RUN: begin
        if (take_w && kind_w == EXC_DABT && fiq_act) begin
          st_nxt = ST_CHAIN;
        end
      end
      ST_CHAIN: begin
        if (ce_i) begin
          st_nxt = ST_RUN;
        end
      end
      default: st_nxt = ST_RUN;
    endcase
  end

  // input synchronizers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fq_s1_r <= 1'b1;
      fq_s2_r <= 1'b1;
      nq_s1_r <= 1'b1;
      nq_s2_r <= 1'b1;
    end else if (ce_i) begin
      fq_s1_r <= fast_request_n_i;
      fq_s2_r <= fq_s1_r;
      nq_s1_r <= normal_request_n_i;
      nq_s2_r <= nq_s1_r;
    end
  end

  // prefetch abort tag tracking
  always_ff @(posedge clk_i) begin
    if (rst_i || (ce_i && (pipe_i.flush || take_w))) begin
      tag_dec_r <= 1'b0;
      tag_exe_r <= 1'b0;
    end else if (ce_i) begin
      if (pipe_i.advance) begin
        tag_exe_r <= tag_dec_r;
        tag_dec_r <= fetch_abt;
      end else if (fetch_abt) begin
        tag_dec_r <= 1'b1;
      end
    end
  end

  // data abort bookkeeping, clear wins over set
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      da_pend_r  <= 1'b0;
      abt_seen_r <= 1'b0;
    end else if (ce_i) begin
      if (dabt_now) begin
        da_pend_r  <= ~(take_w && kind_w == EXC_DABT);
        abt_seen_r <= ~pipe_i.instr_end;
      end else begin
        if (take_w && kind_w == EXC_DABT) begin
          da_pend_r <= 1'b0;
        end
        if (pipe_i.instr_end) begin
          abt_seen_r <= 1'b0;
        end
      end
    end
  end

  // bus write decode, lands at the ack edge
  wire bus_req = wb_cyc_i & wb_stb_i;
  wire csw_wr  = ce_i & bus_req & wb_we_i & ack_r & wb_sel_i[0]
               & (wb_adr_i == `CES_ADR_CSW);

  // status word and entry
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      csw_r   <= ces_status_s'(`CES_CSW_RST);
      st_r    <= ST_RUN;
      entry_r <= '0;
      link_r  <= '0;
      last_r  <= EXC_RESET;
    end else if (ce_i) begin
      st_r          <= st_nxt;
      entry_r.take  <= take_w;
      if (take_w) begin
        entry_r.kind   <= kind_w;
        entry_r.vector <= vec_of(kind_w);
        entry_r.link   <= link_w;
        entry_r.mode   <= new_mode;
        link_r         <= link_w;
        last_r         <= kind_w;
        csw_r.mode     <= new_mode;
        csw_r.i        <= 1'b1;
        csw_r.t        <= 1'b0;
        if (kind_w == EXC_RESET || kind_w == EXC_FIQ) begin
          csw_r.f <= 1'b1;
        end
      end else if (csw_wr) begin
        csw_r <= ces_status_s'(wb_dat_i[7:0]);
      end
    end
  end

  // saved status words
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int n = 0; n < 6; n++) begin
        ssw_r[n] <= '0;
      end
    end else if (ce_i && take_w) begin
      ssw_r[slot_of(new_mode)] <= csw_r;
    end
  end

  // wishbone slave read path
  wire [2:0]  cur_slot = slot_of(csw_r.mode);
  wire [31:0] ssw_rd   = (cur_slot == 3'h5) ? 32'h00000000
                       : {24'h000000, ssw_r[cur_slot]};
  wire [31:0] info_rd  = {24'h000000, st_r, da_pend_r, tag_exe_r,
                          ~nq_s2_r, ~fq_s2_r, last_r};
  wire [31:0] rd_w =
    (wb_adr_i == `CES_ADR_CSW)  ? {24'h000000, csw_r} :
    (wb_adr_i == `CES_ADR_SSW)  ? ssw_rd :
    (wb_adr_i == `CES_ADR_LINK) ? link_r :
    (wb_adr_i == `CES_ADR_INFO) ? info_rd : 32'h00000000;

  // ack one cycle after request, read data latched
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      rd_r  <= '0;
    end else if (ce_i) begin
      ack_r <= bus_req & ~ack_r;
      rd_r  <= rd_w;
    end
  end

  // write suppression strobes
  wire op_ldm  = pipe_i.op == OP_LDM;
  wire op_swap = pipe_i.op == OP_SWAP;
  assign guard_o.rf_block = abt_any & (op_ldm | op_swap
                          | pipe_i.op == OP_LOAD);
  assign guard_o.mem_wr_block = op_swap & (abt_seen_r
                          | (dabt_now & ~mem_i.write));
  assign guard_o.base_revert = abt_any & op_ldm
                          & pipe_i.base_loaded;
  assign guard_o.base_wb_ok = pipe_i.base_wb;
  assign guard_o.pc_keep = abt_any & op_ldm;

  // outputs
  assign entry_o    = entry_r;
  assign status_o   = csw_r;
  assign wb_ack_o   = ack_r;
  assign wb_dat_o   = rd_r;
  assign bank_map_o = (csw_r.mode == `CES_MODE_FIQ && !csw_r.t)
                    ? {BANKED{1'b1}} : {BANKED{1'b0}};

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_sync;
    ce_i [*2] |=> (fq_s2_r == $past(fast_request_n_i, 2));
  endproperty
  a_sync: assert property (p_sync)
    else $error("fast synchronizer delay wrong");

  property p_fiq_mask;
    (take_w && kind_w == EXC_FIQ) |-> !csw_r.f && !fq_s2_r;
  endproperty
  a_fiq_mask: assert property (p_fiq_mask)
    else $error("fast entry while masked");

  property p_irq_rank;
    (take_w && kind_w == EXC_IRQ) |-> !csw_r.i && !fiq_act;
  endproperty
  a_irq_rank: assert property (p_irq_rank)
    else $error("normal entry masked or outranked");

  property p_vec;
    entry_o.take |-> entry_o.vector != `CES_VEC_RSVD
      && entry_o.vector == vec_of(entry_o.kind);
  endproperty
  a_vec: assert property (p_vec)
    else $error("bad vector");

  property p_entry_mask;
    take_w |=> csw_r.i && !csw_r.t && entry_o.take;
  endproperty
  a_entry_mask: assert property (p_entry_mask)
    else $error("entry left masks or state");

  sequence s_dabt_fiq;
    take_w && kind_w == EXC_DABT && fiq_act;
  endsequence
  sequence s_fiq_next;
    !ce_i || reset_req_i || (take_w && kind_w == EXC_FIQ);
  endsequence
  property p_chain;
    s_dabt_fiq |=> s_fiq_next;
  endproperty
  a_chain: assert property (p_chain)
    else $error("fast entry not chained");

  property p_load_block;
    (dabt_now && pipe_i.op == OP_LOAD) |-> guard_o.rf_block;
  endproperty
  a_load_block: assert property (p_load_block)
    else $error("aborted load not blocked");

  property p_swap_wr;
    (dabt_now && op_swap && mem_i.write && !abt_seen_r) |->
      guard_o.rf_block && !guard_o.mem_wr_block;
  endproperty
  a_swap_wr: assert property (p_swap_wr)
    else $error("swap write abort guards wrong");

  property p_fiq_entry;
    (take_w && kind_w == EXC_FIQ) |=>
      csw_r.i && csw_r.f && csw_r.mode == `CES_MODE_FIQ;
  endproperty
  a_fiq_entry: assert property (p_fiq_entry)
    else $error("fast entry left normal unmasked");

  property p_ldm_sticky;
    (dabt_now && op_ldm && !pipe_i.instr_end) |=>
      (guard_o.rf_block && guard_o.pc_keep) || !op_ldm;
  endproperty
  a_ldm_sticky: assert property (p_ldm_sticky)
    else $error("block load write not blocked");

  property p_link;
    (take_w && kind_w == EXC_DABT) |=>
      entry_o.link == $past(pipe_i.pc) + `CES_LINK_FAR;
  endproperty
  a_link: assert property (p_link)
    else $error("data abort link wrong");

  property p_pabt;
    (take_w && kind_w == EXC_PABT) |-> executed && tag_exe_r;
  endproperty
  a_pabt: assert property (p_pabt)
    else $error("prefetch abort on unexecuted");
endmodule // ces_sequencer

/* File: bench/ces_far_model.sv */
`timescale 1ns/10ps
// request pins and memory unit seen from outside the sequencer
module ces_far_model (
  input  wire logic       clk_i,        // bench clock
  input  wire logic       rst_i,        // sync reset, high
  input  wire logic       fast_lvl_i,   // want fast request
  input  wire logic       normal_lvl_i, // want normal request
  input  wire logic       go_i,         // start a memory cycle
  input  wire logic       fetch_i,      // cycle is a prefetch
  input  wire logic       write_i,      // cycle is a write
  input  wire logic       abort_i,      // cycle will abort
  input  wire logic       slow_i,       // add two wait cycles
  output logic            fast_request_n_o,   // pin, low active
  output logic            normal_request_n_o, // pin, low active
  output ces_pkg::ces_mem_s mem_o       // memory report
);
  import ces_pkg::*;
  logic [1:0] cnt_r;  // wait cycles left
  logic       busy_r; // cycle in progress
  logic       junk_r; // abort line is meaningless off done
  logic       fe_r, wr_r, ab_r;
  // pins follow the wanted level, nothing is latched
  always_ff @(posedge clk_i) begin
    fast_request_n_o   <= rst_i | ~fast_lvl_i;
    normal_request_n_o <= rst_i | ~normal_lvl_i;
    junk_r <= ~junk_r;
    mem_o  <= '{1'b0, fe_r, wr_r, junk_r};
    if (rst_i) begin
      busy_r <= 1'b0;
      junk_r <= 1'b0;
    end else if (go_i) begin
      busy_r <= 1'b1;
      cnt_r  <= slow_i ? 2'h2 : 2'h0;
      fe_r   <= fetch_i;
      wr_r   <= write_i;
      ab_r   <= abort_i;
    end else if (busy_r && cnt_r == 2'h0) begin
      mem_o  <= '{1'b1, fe_r, wr_r, ab_r};
      busy_r <= 1'b0;
    end else if (busy_r) begin
      cnt_r <= cnt_r - 2'h1;
    end
  end
endmodule // ces_far_model

/* File: bench/testbench.sv */
`timescale 1ns/10ps
`include "ces_map.svh"
module testbench;
  import ces_pkg::*;
  logic clk_i = 1'b0; // 40 MHz
  logic rst_i = 1'b1; // sync reset
  logic cyc = 0, stb = 0, we = 0, fl = 0, nl = 0, go = 0;
  logic fe = 0, wr = 0, ab = 0, slow = 0, rreq = 0, ce = 1;
  logic [7:0]  adr = 8'h00;
  logic [31:0] dat = 32'h0, q, seed = 32'hCA03551C;
  logic [3:0]  sel = 4'h0;
  wire  [31:0] rdat;
  wire         ack, fast_n, norm_n;
  wire  [7:0]  bank;
  ces_mem_s    mem;
  ces_pipe_s   pipe = '{op: OP_OTHER, exec_valid: 1'b1, cond_pass: 1'b1,
                        default: '0};
  ces_entry_s  entry, last, prev;
  ces_status_s status;
  ces_guard_s  guard;
  int mismatches = 0, n_checks = 0, n_take = 0, t0;
  ces_op_e    ops [4] = '{OP_LOAD, OP_SWAP, OP_SWAP, OP_LDM};
  logic [4:0] gexp [4] = '{5'h10, 5'h18, 5'h10, 5'h17}; // guard expected
  logic [4:0] gmsk [4] = '{5'h10, 5'h18, 5'h18, 5'h17}; // guard bits cared
  always #12.5 clk_i = ~clk_i;
  ces_far_model far (.clk_i(clk_i), .rst_i(rst_i), .fast_lvl_i(fl),
    .normal_lvl_i(nl), .go_i(go), .fetch_i(fe), .write_i(wr),
    .abort_i(ab), .slow_i(slow), .fast_request_n_o(fast_n),
    .normal_request_n_o(norm_n), .mem_o(mem));
  ces_sequencer DUT (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_dat_i(dat), .wb_sel_i(sel), .wb_dat_o(rdat), .wb_ack_o(ack),
    .fast_request_n_i(fast_n), .normal_request_n_i(norm_n),
    .reset_req_i(rreq), .mem_i(mem), .pipe_i(pipe), .entry_o(entry),
    .status_o(status), .guard_o(guard), .bank_map_o(bank));
  // next pseudo random word
  function logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h0);
  endfunction
  // expected link from the address and the abort kind
  function logic [31:0] lnk(input logic far_off);
    return pipe.pc + (far_off ? `CES_LINK_FAR : `CES_LINK_NEAR);
  endfunction
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task test_done();
    if (mismatches == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // one classic wishbone cycle, held until ack
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d; sel <= 4'hF;
    t = 0;
    do begin @(posedge clk_i); t++; end while (ack !== 1'b1 && t < 50);
    if (t >= 50) chk("bus ack", 1, 0);
    q = rdat;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    @(posedge clk_i);
  endtask
  task csw(input logic [7:0] v);
    wb(1'b1, `CES_ADR_CSW, {24'h0, v});
  endtask
  // instruction boundary at a fresh random address
  task bnd();
    seed = lfsr(seed);
    pipe.pc <= {seed[31:2], 2'b00};
    pipe.instr_end <= 1'b1;
    @(posedge clk_i);
    pipe.instr_end <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask
  // aborting memory cycle, returns in the done cycle
  task acc(input logic f, input logic w, input logic s);
    int t;
    go <= 1'b1; fe <= f; wr <= w; ab <= 1'b1; slow <= s;
    @(posedge clk_i);
    go <= 1'b0;
    t = 0;
    do begin @(negedge clk_i); t++; end while (mem.done !== 1'b1 && t < 20);
    if (t >= 20) chk("mem done", 1, 0);
  endtask
  task adv();
    pipe.advance <= 1'b1;
    @(posedge clk_i);
    pipe.advance <= 1'b0;
  endtask
  task ent(input ces_exc_e k, input logic [31:0] v, input logic [4:0] m,
           input logic [31:0] l);
    chk("kind", k, last.kind);
    chk("vector", v, last.vector);
    chk("mode", m, last.mode);
    chk("link", l, last.link);
  endtask
  // record every entry pulse
  always @(posedge clk_i) if (entry.take === 1'b1) begin
    n_take <= n_take + 1;
    prev <= last;
    last <= entry;
    chk("reserved", 0, entry.vector === `CES_VEC_RSVD);
  end
  initial begin
    #(25 * 4000);
    mismatches++;
    test_done();
  end
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk("status", `CES_CSW_RST, status);
    wb(1'b0, 8'h40, 32'h0);
    chk("unmapped", 0, q);
    csw(8'h33); // compact state, unmasked
    wb(1'b0, `CES_ADR_CSW, 32'h0);
    chk("csw", 32'h33, q);
    fl <= 1'b1;
    repeat (4) @(posedge clk_i);
    bnd();
    ent(EXC_FIQ, `CES_VEC_FIQ, `CES_MODE_FIQ, lnk(0));
    chk("status", 8'hD1, status);
    chk("bank", 8'hFF, bank);
    nl <= 1'b1; // both masked now
    repeat (4) @(posedge clk_i);
    t0 = n_take;
    bnd();
    chk("takes", t0, n_take);
    fl <= 1'b0; nl <= 1'b0;
    csw(8'h13);
    fl <= 1'b1; // short pulse gone before boundary
    @(posedge clk_i);
    fl <= 1'b0;
    repeat (4) @(posedge clk_i);
    bnd();
    chk("takes", t0, n_take);
    fl <= 1'b1; nl <= 1'b1; pipe.undef <= 1'b1;
    repeat (4) @(posedge clk_i);
    bnd();
    ent(EXC_FIQ, `CES_VEC_FIQ, `CES_MODE_FIQ, lnk(0));
    fl <= 1'b0;
    csw(8'h13);
    bnd();
    ent(EXC_IRQ, `CES_VEC_IRQ, `CES_MODE_IRQ, lnk(0));
    chk("status", 8'h92, status);
    chk("bank", 8'h00, bank);
    nl <= 1'b0;
    bnd();
    ent(EXC_UNDEF, `CES_VEC_UNDEF, `CES_MODE_UND, lnk(0));
    chk("status", 8'h9B, status);
    pipe.undef <= 1'b0; pipe.swtrap <= 1'b1;
    bnd();
    ent(EXC_TRAP, `CES_VEC_TRAP, `CES_MODE_SVC, lnk(0));
    pipe.swtrap <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      csw(8'h13);
      fl <= (i == 3);
      pipe.op <= ops[i]; pipe.base_wb <= 1'b1; pipe.base_loaded <= (i == 3);
      acc(1'b0, i == 2, i[0]);
      chk("guard", gexp[i], guard & gmsk[i]);
      @(negedge clk_i);
      if (i > 0) chk("sticky", 1, guard.rf_block);
      @(posedge clk_i);
      bnd();
      if (i == 3) begin
        chk("first", EXC_DABT, prev.kind);
        ent(EXC_FIQ, `CES_VEC_FIQ, `CES_MODE_FIQ, lnk(0));
      end else
        ent(EXC_DABT, `CES_VEC_DABT, `CES_MODE_ABT, lnk(1));
    end
    fl <= 1'b0; pipe.op <= OP_OTHER;
    acc(1'b1, 1'b0, 1'b1);
    @(posedge clk_i);
    adv();
    bnd();
    ent(EXC_PABT, `CES_VEC_PABT, `CES_MODE_ABT, lnk(0));
    acc(1'b1, 1'b0, 1'b0);
    @(posedge clk_i);
    adv();
    pipe.cond_pass <= 1'b0;
    t0 = n_take;
    bnd();
    chk("takes", t0, n_take);
    pipe.cond_pass <= 1'b1; pipe.flush <= 1'b1;
    @(posedge clk_i);
    pipe.flush <= 1'b0;
    bnd();
    chk("takes", t0, n_take);
    t0 = n_take;
    ce <= 1'b0; // frozen, request must wait
    rreq <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk("takes", t0, n_take);
    chk("status", 8'hD7, status);
    ce <= 1'b1;
    @(posedge clk_i);
    rreq <= 1'b0;
    repeat (3) @(posedge clk_i);
    ent(EXC_RESET, `CES_VEC_RESET, `CES_MODE_SVC, lnk(0));
    chk("status", `CES_CSW_RST, status);
    wb(1'b0, `CES_ADR_LINK, 32'h0);
    chk("link reg", lnk(0), q);
    wb(1'b0, `CES_ADR_SSW, 32'h0);
    chk("saved status", 32'hD7, q);
    test_done();
  end
endmodule // testbench
